/* cbde_exec.sv */
/*
 * Execution slice for compare-skip-if-less, decimal adjust and decrement-file,
 * with working register, flags, bank select and a 4 KB data memory,
 * all reached over an Avalon-MM slave with waitrequest.
 * Assumes one 250 MHz clock, synchronous active-high reset, and that
 * software says via a control bit whether the following word is two-word.
 */
// Decided for this implementation: the Avalon-MM slave port and the address map.
// Behaviour
// [RULE_01] Compare-skip takes 1 cycle, 2 on skip, 3 skipping a two-word instruction
// [RULE_02] Each skipped word becomes a full instruction cycle of no operation
// [RULE_03] Unsigned file minus working register; skip when file is smaller
// [RULE_04] Decimal adjust adds 6 to low nibble if above 9 or digit carry
// [RULE_05] High nibble gets 6 plus low carry if above 9 or carry; sets carry (code: C takes the high-nibble carry out, cleared when that sum stays below 16)
// [RULE_06] Decrement-file subtracts one and updates C, DC, N, OV and Z
// [RULE_07] Destination bit 0 writes working register, 1 writes file back
// [RULE_08] Bank bit 0 uses access bank, else bank select picks the bank
// [RULE_09] Bank bit 0 with extended set and address up to 95 is index-relative
module cbde_exec
    import cbde_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic [5:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest
);
    // ---------------------------------------------------------------
    // State
    // ---------------------------------------------------------------
    cbde_state_t state_reg;
    logic [1:0] q_reg;
    logic [1:0] cycles_reg;
    logic skipped_reg;
    logic rd_pend_reg;
    logic [1:0] ctrl_reg;
    logic [15:0] instr_reg;
    logic [7:0] wreg_reg;
    logic [4:0] status_reg;
    logic [3:0] bank_select_register_reg;
    logic [11:0] index_reg;
    logic [11:0] mem_addr_reg;
    logic [7:0] opnd_reg;
    logic [7:0] result_reg;
    logic [4:0] flags_next;
    logic [7:0] mem [0:4095];
    logic busy;
    logic bus_wr;
    logic launch;
    logic q4;
    logic is_cmp;
    logic is_daa;
    logic is_dec;
    logic less;
    logic [11:0] ea;
    logic [7:0] dec_res;
    logic [4:0] lo_sum;
    logic [4:0] hi_sum;

    // ---------------------------------------------------------------
    // Decoding
    // ---------------------------------------------------------------
    function automatic logic [11:0] eff_addr(input logic [15:0] op, input logic [3:0] bank,
                                             input logic ext, input logic [11:0] idx);
        logic [7:0] f;
        f = op[7:0];
        if (op[CBDE_OP_A])
            eff_addr = {bank, f}; // see [RULE_08]
        else if (ext && f <= CBDE_LIT_MAX)
            eff_addr = idx + {4'h0, f}; // see [RULE_09]
        else if (f <= CBDE_LIT_MAX)
            eff_addr = {4'h0, f}; // see [RULE_08]
        else
            eff_addr = {CBDE_ACC_HIGH_BANK, f};
    endfunction

    assign busy = (state_reg != CBDE_IDLE);
    assign bus_wr = avs_write && !busy;
    assign launch = bus_wr && (avs_address == CBDE_OFF_INSTR);
    assign q4 = (q_reg == CBDE_Q_LAST);
    assign is_cmp = (instr_reg[15:9] == CBDE_OPC_CMP_LT);
    assign is_daa = (instr_reg == CBDE_OPC_DAA);
    assign is_dec = (instr_reg[15:10] == CBDE_OPC_DEC);
    assign ea = eff_addr(instr_reg, bank_select_register_reg, ctrl_reg[CBDE_CTRL_EXT], index_reg);
    assign less = (opnd_reg < wreg_reg); // see [RULE_03]
    // Reads wait one cycle so read data comes from a flip-flop
    assign avs_waitrequest = (avs_read && !rd_pend_reg) || (avs_write && busy);

    // ---------------------------------------------------------------
    // Arithmetic
    // ---------------------------------------------------------------
    always_comb begin
        dec_res = opnd_reg - 8'h01; // see [RULE_06]
        lo_sum = {1'b0, opnd_reg[3:0]};
        if (opnd_reg[3:0] > CBDE_BCD_MAX || status_reg[CBDE_ST_DC])
            lo_sum = {1'b0, opnd_reg[3:0]} + {1'b0, CBDE_BCD_FIX}; // see [RULE_04]
        hi_sum = {1'b0, opnd_reg[7:4]} + {4'h0, lo_sum[4]};
        if (opnd_reg[7:4] > CBDE_BCD_MAX || status_reg[CBDE_ST_C])
            hi_sum = hi_sum + {1'b0, CBDE_BCD_FIX}; // see [RULE_05]
        flags_next = status_reg;
        if (is_dec) begin
            flags_next[CBDE_ST_C] = (opnd_reg != 8'h00); // see [RULE_06]
            flags_next[CBDE_ST_DC] = (opnd_reg[3:0] != 4'h0);
            flags_next[CBDE_ST_Z] = (dec_res == 8'h00);
            flags_next[CBDE_ST_OV] = (opnd_reg == 8'h80);
            flags_next[CBDE_ST_N] = dec_res[7];
        end else if (is_daa) begin
            flags_next[CBDE_ST_C] = hi_sum[4]; // see [RULE_05]
        end
    end

    // ---------------------------------------------------------------
    // Sequencer: four phases per instruction cycle
    // ---------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (rst) begin
            state_reg <= CBDE_IDLE;
            q_reg <= 2'h0;
        end else begin
            q_reg <= busy ? q_reg + 2'h1 : 2'h0;
            case (state_reg)
                CBDE_IDLE: begin
                    if (launch)
                        state_reg <= CBDE_EXEC;
                end
                CBDE_EXEC: begin
                    if (q4)
                        state_reg <= (is_cmp && less) ? CBDE_SKIP1 : CBDE_IDLE; // see [RULE_03]
                end
                CBDE_SKIP1: begin
                    if (q4)
                        state_reg <= ctrl_reg[CBDE_CTRL_TWO_WORD] ? CBDE_SKIP2 // see [RULE_02]
                                                                   : CBDE_IDLE;
                end
                CBDE_SKIP2: begin
                    if (q4)
                        state_reg <= CBDE_IDLE;
                end
                default: state_reg <= CBDE_IDLE;
            endcase
        end
    end

    // Counts instruction cycles spent by the last instruction
    always_ff @(posedge clock) begin
        if (rst) begin
            cycles_reg <= 2'h0;
            skipped_reg <= 1'b0;
        end else if (launch) begin
            cycles_reg <= 2'h0;
            skipped_reg <= 1'b0;
        end else if (busy && q4) begin
            cycles_reg <= cycles_reg + 2'h1; // see [RULE_01]
            if (state_reg == CBDE_EXEC)
                skipped_reg <= is_cmp && less;
        end
    end

    // ---------------------------------------------------------------
    // Datapath: operand in phase 2, result in phase 3
    // ---------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (rst) begin
            opnd_reg <= 8'h00;
            result_reg <= 8'h00;
        end else if (state_reg == CBDE_EXEC) begin
            if (q_reg == 2'h1)
                opnd_reg <= is_daa ? wreg_reg : mem[ea];
            if (q_reg == 2'h2)
                result_reg <= is_daa ? {hi_sum[3:0], lo_sum[3:0]} : dec_res;
        end
    end

    always_ff @(posedge clock) begin
        if (rst)
            status_reg <= CBDE_STATUS_RST;
        else if (state_reg == CBDE_EXEC && q4)
            status_reg <= flags_next; // see [RULE_06]
        else if (bus_wr && avs_address == CBDE_OFF_STATUS)
            status_reg <= avs_writedata[4:0];
    end

    always_ff @(posedge clock) begin
        if (rst)
            wreg_reg <= CBDE_WREG_RST;
        else if (state_reg == CBDE_EXEC && q4 && (is_daa || (is_dec && !instr_reg[CBDE_OP_D])))
            wreg_reg <= result_reg; // see [RULE_07]
        else if (bus_wr && avs_address == CBDE_OFF_WREG)
            wreg_reg <= avs_writedata[7:0];
    end

    // Skip cycles never reach the memory port
    always_ff @(posedge clock) begin
        if (state_reg == CBDE_EXEC && q4 && is_dec && instr_reg[CBDE_OP_D])
            mem[ea] <= result_reg; // see [RULE_07]
        else if (bus_wr && avs_address == CBDE_OFF_MEM_DATA)
            mem[mem_addr_reg] <= avs_writedata[7:0];
    end

    // ---------------------------------------------------------------
    // Register bus
    // ---------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (rst) begin
            ctrl_reg <= CBDE_CTRL_RST;
            instr_reg <= CBDE_INSTR_RST;
            bank_select_register_reg <= CBDE_BANK_RST;
            index_reg <= CBDE_INDEX_RST;
            mem_addr_reg <= 12'h000;
        end else if (bus_wr) begin
            case (avs_address)
                CBDE_OFF_CTRL: ctrl_reg <= avs_writedata[1:0];
                CBDE_OFF_INSTR: instr_reg <= avs_writedata[15:0];
                CBDE_OFF_BANK: bank_select_register_reg <= avs_writedata[3:0];
                CBDE_OFF_INDEX: index_reg <= avs_writedata[11:0];
                CBDE_OFF_MEM_ADDR: mem_addr_reg <= avs_writedata[11:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            rd_pend_reg <= 1'b0;
            avs_readdata <= 32'h0000_0000;
        end else begin
            rd_pend_reg <= avs_read && !rd_pend_reg;
            if (avs_read && !rd_pend_reg) begin
                case (avs_address)
                    CBDE_OFF_CTRL: avs_readdata <= {30'h0, ctrl_reg};
                    CBDE_OFF_INSTR: avs_readdata <= {16'h0, instr_reg};
                    CBDE_OFF_WREG: avs_readdata <= {24'h0, wreg_reg};
                    CBDE_OFF_STATUS: avs_readdata <= {27'h0, status_reg};
                    CBDE_OFF_BANK: avs_readdata <= {28'h0, bank_select_register_reg};
                    CBDE_OFF_INDEX: avs_readdata <= {20'h0, index_reg};
                    CBDE_OFF_MEM_ADDR: avs_readdata <= {20'h0, mem_addr_reg};
                    CBDE_OFF_MEM_DATA: avs_readdata <= {24'h0, mem[mem_addr_reg]};
                    CBDE_OFF_EXEC: avs_readdata <= {26'h0, cycles_reg, 2'h0, skipped_reg, busy};
                    default: avs_readdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    property p_cycle_count;
        @(posedge clock) disable iff (rst)
        $fell(busy) |-> cycles_reg == (!skipped_reg ? 2'h1 :
                                       (ctrl_reg[CBDE_CTRL_TWO_WORD] ? 2'h3 : 2'h2));
    endproperty
    a_cycle_count: assert property (p_cycle_count) else $error("bad cycles"); // see [RULE_01]

    property p_skip_nop;
        @(posedge clock) disable iff (rst)
        (state_reg == CBDE_SKIP1 || state_reg == CBDE_SKIP2)
            |=> $stable(wreg_reg) && $stable(status_reg);
    endproperty
    a_skip_nop: assert property (p_skip_nop) else $error("skip changed state"); // see [RULE_02]

    property p_cmp_skip;
        @(posedge clock) disable iff (rst)
        (state_reg == CBDE_EXEC && q4 && is_cmp)
            |=> (state_reg == CBDE_SKIP1) == ($past(opnd_reg) < $past(wreg_reg));
    endproperty
    a_cmp_skip: assert property (p_cmp_skip) else $error("compare skip wrong"); // see [RULE_03]

    property p_daa_low;
        @(posedge clock) disable iff (rst)
        (state_reg == CBDE_EXEC && q4 && is_daa) |=> wreg_reg[3:0] ==
            (($past(opnd_reg[3:0]) > 4'h9 || $past(status_reg[CBDE_ST_DC])) ?
             $past(opnd_reg[3:0]) + 4'h6 : $past(opnd_reg[3:0]));
    endproperty
    a_daa_low: assert property (p_daa_low) else $error("adjust low wrong"); // see [RULE_04]

    property p_daa_carry;
        @(posedge clock) disable iff (rst)
        (state_reg == CBDE_EXEC && q4 && is_daa && opnd_reg[7:4] > 4'h9)
            |=> status_reg[CBDE_ST_C];
    endproperty
    a_daa_carry: assert property (p_daa_carry) else $error("adjust carry lost"); // see [RULE_05]

    property p_dec_flags;
        @(posedge clock) disable iff (rst)
        (state_reg == CBDE_EXEC && q4 && is_dec) |=>
            status_reg[CBDE_ST_Z] == ($past(opnd_reg) == 8'h01) &&
            status_reg[CBDE_ST_C] == ($past(opnd_reg) != 8'h00);
    endproperty
    a_dec_flags: assert property (p_dec_flags) else $error("decrement flags"); // see [RULE_06]

    property p_dec_to_w;
        @(posedge clock) disable iff (rst)
        (state_reg == CBDE_EXEC && q_reg == 2'h2 && is_dec && !instr_reg[CBDE_OP_D])
            |=> ##1 wreg_reg == $past(opnd_reg, 2) - 8'h01;
    endproperty
    a_dec_to_w: assert property (p_dec_to_w) else $error("decrement to W wrong"); // see [RULE_07]

    property p_bank_sel;
        @(posedge clock) disable iff (rst)
        (state_reg == CBDE_EXEC && q_reg == 2'h1 && (is_cmp || is_dec) && instr_reg[CBDE_OP_A])
            |=> opnd_reg == $past(mem[{bank_select_register_reg, instr_reg[7:0]}]);
    endproperty
    a_bank_sel: assert property (p_bank_sel) else $error("bank select not used"); // see [RULE_08]

    property p_indexed;
        @(posedge clock) disable iff (rst)
        (state_reg == CBDE_EXEC && q_reg == 2'h1 && (is_cmp || is_dec) && !instr_reg[CBDE_OP_A]
            && ctrl_reg[CBDE_CTRL_EXT] && instr_reg[7:0] <= 8'h5f)
            |=> opnd_reg == $past(mem[index_reg + {4'h0, instr_reg[7:0]}]);
    endproperty
    a_indexed: assert property (p_indexed) else $error("indexed offset wrong"); // see [RULE_09]
endmodule // cbde_exec

/* cbde_pkg.sv */
/*
 * Constants for the compare, decimal adjust and decrement execution slice:
 * register offsets, field positions, reset values, opcode patterns, states.
 * Assumes a 32-bit Avalon-MM register bus with byte addresses.
 */
package cbde_pkg;
    // ---------------------------------------------------------------
    // Register byte offsets
    // ---------------------------------------------------------------
    localparam logic [5:0] CBDE_OFF_CTRL = 6'h00;
    localparam logic [5:0] CBDE_OFF_INSTR = 6'h04;
    localparam logic [5:0] CBDE_OFF_WREG = 6'h08;
    localparam logic [5:0] CBDE_OFF_STATUS = 6'h0c;
    localparam logic [5:0] CBDE_OFF_BANK = 6'h10;
    localparam logic [5:0] CBDE_OFF_INDEX = 6'h14;
    localparam logic [5:0] CBDE_OFF_MEM_ADDR = 6'h18;
    localparam logic [5:0] CBDE_OFF_MEM_DATA = 6'h1c;
    localparam logic [5:0] CBDE_OFF_EXEC = 6'h20;
    // ---------------------------------------------------------------
    // Field positions
    // ---------------------------------------------------------------
    localparam int CBDE_CTRL_EXT = 0;
    localparam int CBDE_CTRL_TWO_WORD = 1;
    localparam int CBDE_ST_C = 0;
    localparam int CBDE_ST_DC = 1;
    localparam int CBDE_ST_Z = 2;
    localparam int CBDE_ST_OV = 3;
    localparam int CBDE_ST_N = 4;
    localparam int CBDE_OP_D = 9;
    localparam int CBDE_OP_A = 8;
    // ---------------------------------------------------------------
    // Reset values and constants
    // ---------------------------------------------------------------
    localparam logic [7:0] CBDE_WREG_RST = 8'h00;
    localparam logic [4:0] CBDE_STATUS_RST = 5'h00;
    localparam logic [3:0] CBDE_BANK_RST = 4'h0;
    localparam logic [11:0] CBDE_INDEX_RST = 12'h000;
    localparam logic [1:0] CBDE_CTRL_RST = 2'h0;
    localparam logic [15:0] CBDE_INSTR_RST = 16'h0000;
    localparam logic [1:0] CBDE_Q_LAST = 2'h3;
    localparam logic [7:0] CBDE_LIT_MAX = 8'h5f;
    localparam logic [3:0] CBDE_ACC_HIGH_BANK = 4'hf;
    localparam logic [3:0] CBDE_BCD_MAX = 4'h9;
    localparam logic [3:0] CBDE_BCD_FIX = 4'h6;
    // ---------------------------------------------------------------
    // Opcode patterns
    // ---------------------------------------------------------------
    localparam logic [6:0] CBDE_OPC_CMP_LT = 7'h30;
    localparam logic [5:0] CBDE_OPC_DEC = 6'h01;
    localparam logic [15:0] CBDE_OPC_DAA = 16'h0007;
    // ---------------------------------------------------------------
    // Sequencer states, Gray along idle, exec, skip, skip
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {
        CBDE_IDLE = 2'b00,
        CBDE_EXEC = 2'b01,
        CBDE_SKIP1 = 2'b11,
        CBDE_SKIP2 = 2'b10
    } cbde_state_t;
endpackage

/* tb_top.sv */
/*
 * Self-checking bench for the compare, decimal adjust and decrement slice.
 * Assumes cbde_pkg and cbde_exec are compiled first; drives reset and the Avalon-MM port only.
 */
module tb_top
    import cbde_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    // ---------------------------------------------------------------
    // Stimulus table
    // ---------------------------------------------------------------
    typedef struct packed {
        logic [1:0] ctrl;
        logic [7:0] w;
        logic [4:0] st;
        logic [3:0] bank;
        logic [11:0] idx;
        logic [11:0] ma;
        logic [7:0] md;
        logic [15:0] ins;
        logic [7:0] ew;
        logic [4:0] est;
        logic [7:0] emd;
        logic [1:0] cyc;
        logic skp;
    } cbde_row_t;
    // Columns: ctrl w st bank idx addr mem instr | w st mem cycles skip
    cbde_row_t rows [16] = '{
        '{2'h0, 8'ha5, 5'h00, 4'h0, 12'h000, 12'h100, 8'h11, 16'h0007,
          8'h05, 5'h01, 8'h11, 2'h1, 1'b0},
        '{2'h0, 8'h34, 5'h03, 4'h0, 12'h000, 12'h100, 8'h11, 16'h0007,
          8'h9a, 5'h02, 8'h11, 2'h1, 1'b0},
        '{2'h0, 8'h9a, 5'h00, 4'h0, 12'h000, 12'h100, 8'h11, 16'h0007,
          8'ha0, 5'h00, 8'h11, 2'h1, 1'b0},
        '{2'h0, 8'h99, 5'h01, 4'h0, 12'h000, 12'h100, 8'h11, 16'h0007,
          8'hf9, 5'h00, 8'h11, 2'h1, 1'b0},
        '{2'h0, 8'h55, 5'h00, 4'h3, 12'h000, 12'h320, 8'h01, 16'h0720,
          8'h55, 5'h07, 8'h00, 2'h1, 1'b0},
        '{2'h0, 8'h55, 5'h0f, 4'h2, 12'h000, 12'h240, 8'h00, 16'h0540,
          8'hff, 5'h10, 8'h00, 2'h1, 1'b0},
        '{2'h0, 8'h55, 5'h00, 4'h5, 12'h000, 12'hfa0, 8'h80, 16'h06a0,
          8'h55, 5'h09, 8'h7f, 2'h1, 1'b0},
        '{2'h1, 8'h55, 5'h00, 4'h5, 12'h123, 12'h133, 8'h10, 16'h0610,
          8'h55, 5'h01, 8'h0f, 2'h1, 1'b0},
        '{2'h1, 8'h55, 5'h00, 4'h4, 12'h123, 12'h410, 8'h05, 16'h0710,
          8'h55, 5'h03, 8'h04, 2'h1, 1'b0},
        '{2'h1, 8'h55, 5'h00, 4'h1, 12'h200, 12'hf60, 8'h02, 16'h0660,
          8'h55, 5'h03, 8'h01, 2'h1, 1'b0},
        '{2'h0, 8'h20, 5'h0a, 4'h1, 12'h000, 12'h105, 8'h10, 16'h6105,
          8'h20, 5'h0a, 8'h10, 2'h2, 1'b1},
        '{2'h2, 8'h20, 5'h0a, 4'h1, 12'h000, 12'h105, 8'h10, 16'h6105,
          8'h20, 5'h0a, 8'h10, 2'h3, 1'b1},
        '{2'h2, 8'h20, 5'h0a, 4'h1, 12'h000, 12'h105, 8'h20, 16'h6105,
          8'h20, 5'h0a, 8'h20, 2'h1, 1'b0},
        '{2'h0, 8'h20, 5'h0a, 4'h1, 12'h000, 12'h005, 8'h21, 16'h6005,
          8'h20, 5'h0a, 8'h21, 2'h1, 1'b0},
        '{2'h1, 8'h01, 5'h00, 4'h1, 12'h200, 12'h25f, 8'h00, 16'h605f,
          8'h01, 5'h00, 8'h00, 2'h2, 1'b1},
        '{2'h0, 8'h42, 5'h05, 4'h0, 12'h000, 12'h100, 8'h11, 16'hffff,
          8'h42, 5'h05, 8'h11, 2'h1, 1'b0}
    };
    logic clock = 1'b0;
    logic rst;
    logic [5:0] avs_address;
    logic avs_read;
    logic avs_write;
    logic [31:0] avs_writedata;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    int num_errors = 0;
    int checks_done = 0;
    cbde_row_t r;
    logic [31:0] d;
    int w;
    always #2 clock = ~clock;
    cbde_exec u_dut (
        .clock(clock),
        .rst(rst),
        .avs_address(avs_address),
        .avs_read(avs_read),
        .avs_write(avs_write),
        .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest)
    );
    // ---------------------------------------------------------------
    // Bus and check tasks
    // ---------------------------------------------------------------
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // Idle edge after release so the next request never lands in the same step
    task automatic bus_wr(input logic [5:0] a, input logic [31:0] v, output int waits);
        waits = 0;
        avs_address <= a;
        avs_writedata <= v;
        avs_write <= 1'b1;
        @(posedge clock);
        // No local limit: only the watchdog may end a stalled wait
        while (avs_waitrequest !== 1'b0) begin
            waits++;
            @(posedge clock);
        end
        avs_write <= 1'b0;
        @(posedge clock);
    endtask
    task automatic bus_rd(input logic [5:0] a, output logic [31:0] v);
        avs_address <= a;
        avs_read <= 1'b1;
        @(posedge clock);
        while (avs_waitrequest !== 1'b0) begin
            @(posedge clock);
        end
        v = avs_readdata;
        avs_read <= 1'b0;
        @(posedge clock);
    endtask
    task automatic chk_reset;
        logic [5:0] offs [6];
        logic [31:0] v;
        offs = '{CBDE_OFF_CTRL, CBDE_OFF_WREG, CBDE_OFF_STATUS, CBDE_OFF_BANK,
                 CBDE_OFF_INDEX, CBDE_OFF_EXEC};
        foreach (offs[k]) begin
            bus_rd(offs[k], v);
            chk("reset value", v, 32'h0);
        end
    endtask
    task automatic results;
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // ---------------------------------------------------------------
    // Watchdog
    // ---------------------------------------------------------------
    initial begin
        #80000;
        num_errors++;
        $display("[ERR] watchdog expected finish seen hang");
        results();
    end
    // ---------------------------------------------------------------
    // Main sequence
    // ---------------------------------------------------------------
    initial begin
        rst <= 1'b1;
        avs_address <= 6'h00;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        avs_writedata <= 32'h0;
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        chk_reset();
        foreach (rows[i]) begin
            r = rows[i];
            bus_wr(CBDE_OFF_CTRL, {30'h0, r.ctrl}, w);
            bus_wr(CBDE_OFF_WREG, {24'h0, r.w}, w);
            bus_wr(CBDE_OFF_STATUS, {27'h0, r.st}, w);
            bus_wr(CBDE_OFF_BANK, {28'h0, r.bank}, w);
            bus_wr(CBDE_OFF_INDEX, {20'h0, r.idx}, w);
            bus_wr(CBDE_OFF_MEM_ADDR, {20'h0, r.ma}, w);
            bus_wr(CBDE_OFF_MEM_DATA, {24'h0, r.md}, w);
            bus_wr(CBDE_OFF_INSTR, {16'h0, r.ins}, w);
            // Stalled write measures how long the instruction kept the slice busy
            bus_wr(CBDE_OFF_MEM_ADDR, {20'h0, r.ma}, w);
            chk("stall cycles", 32'(w), 32'(4 * r.cyc - 1));
            bus_rd(CBDE_OFF_WREG, d);
            chk("wreg", d, {24'h0, r.ew});
            bus_rd(CBDE_OFF_STATUS, d);
            chk("status", d, {27'h0, r.est});
            bus_rd(CBDE_OFF_MEM_DATA, d);
            chk("memory", d, {24'h0, r.emd});
            bus_rd(CBDE_OFF_EXEC, d);
            chk("exec", {28'h0, d[5:4], d[1:0]}, {28'h0, r.cyc, r.skp, 1'b0});
        end
        // Unmapped place: write ignored, read gives zero
        bus_wr(6'h3c, 32'h000000a5, w);
        bus_rd(6'h3c, d);
        chk("unmapped", d, 32'h0);
        // Second reset in mid-run clears the registers again
        bus_wr(CBDE_OFF_WREG, 32'h00000077, w);
        rst <= 1'b1;
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        chk_reset();
        results();
    end
endmodule // tb_top
